// file: logic/dspr_regs.sv
/*
 * step control, channel power and pll power registers with step sequencing.
 * assumes the configuration port front end delivers one-cycle read/write strobes on CLK.
 */
`timescale 1ns/100ps
// Functional notes
// - bits 8,7 include integer dividers of channels 2,1 in steps; reset excluded.
// - bits 6..3 include fractional dividers of channels 4..1 in steps.
// - writing one to bit 2 steps included words down, then clears itself.
// - writing one to bit 1 steps included words up, then clears itself.
// - bit 0 zero takes steps from pins, one from register bits.
// - integer and fractional dividers use their own step-size settings.
// - power bits 7,5,3,1 switch off channel 4..1 regulators when set.
// - power bits 6,4,2,0 switch off channel 4..1 fractional dividers when set.
// - channel power register at 4h, reset 54h.
// - channel power bits 15..8 reserved, read-write, reset zero.
// - pll power register decoded at 5h, reset 30h.
// - step control register at 3h, reset zero.
// - bits 10,9 include integer dividers of channels 4,3 in steps.
module dspr_regs
   import dspr_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // register port
   input wire dspr_req_type REQ,
   output logic [DATA_W-1:0] RDATA,
   output logic RVALID,
   // step pins
   input wire logic STEP_UP_PIN,
   input wire logic STEP_DOWN_PIN,
   // step sizes and divider words
   input wire logic [INT_W-1:0] INT_STEP_SIZE,
   input wire logic [FRAC_W-1:0] FRAC_STEP_SIZE,
   input wire logic [NUM_CH-1:0] DIV_BOUNDARY,
   input wire logic [NUM_CH*INT_W-1:0] INT_WORD_INIT,
   input wire logic [NUM_CH*FRAC_W-1:0] FRAC_WORD_INIT,
   output logic [NUM_CH*INT_W-1:0] INT_WORD,
   output logic [NUM_CH*FRAC_W-1:0] FRAC_WORD,
   // power controls
   output logic [NUM_CH-1:0] REGULATOR_OFF,
   output logic [NUM_CH-1:0] FRAC_DIVIDER_OFF,
   output logic [DATA_W-1:0] PLL_POWER_DOWN
);
   logic [DATA_W-1:0] step_ctrl_ff, nxt_step_ctrl;
   logic [DATA_W-1:0] chan_pwr_ff, nxt_chan_pwr;
   logic [DATA_W-1:0] pll_pwr_ff, nxt_pll_pwr;
   logic [DATA_W-1:0] rdata_ff, nxt_rdata;
   logic rvalid_ff, nxt_rvalid;
   logic reg_up_ff, nxt_reg_up;
   logic reg_down_ff, nxt_reg_down;
   logic [PIN_SYNC-1:0] up_sync_ff, down_sync_ff;
   logic up_level_ff, down_level_ff;
   logic nxt_up_level, nxt_down_level;
   logic pin_up_edge, pin_down_edge;
   logic step_valid;
   dspr_step_type step;

   // three-stage pin synchronisers; a change counts once stages two and three agree
   always_ff @(posedge CLK) begin
      if (RST) begin
         up_sync_ff <= '0;
         down_sync_ff <= '0;
         up_level_ff <= 1'b0;
         down_level_ff <= 1'b0;
      end else begin
         up_sync_ff <= {up_sync_ff[PIN_SYNC-2:0], STEP_UP_PIN};
         down_sync_ff <= {down_sync_ff[PIN_SYNC-2:0], STEP_DOWN_PIN};
         up_level_ff <= nxt_up_level;
         down_level_ff <= nxt_down_level;
      end
   end

   always_comb begin
      nxt_up_level = up_level_ff;
      nxt_down_level = down_level_ff;
      if (up_sync_ff[1] == up_sync_ff[2]) begin
         nxt_up_level = up_sync_ff[2];
      end
      if (down_sync_ff[1] == down_sync_ff[2]) begin
         nxt_down_level = down_sync_ff[2];
      end
   end

   // a pin step is one rising edge of the filtered level
   assign pin_up_edge = nxt_up_level && !up_level_ff;
   assign pin_down_edge = nxt_down_level && !down_level_ff;

   // register writes and self-clearing step bits
   always_comb begin
      nxt_step_ctrl = step_ctrl_ff;
      nxt_chan_pwr = chan_pwr_ff;
      nxt_pll_pwr = pll_pwr_ff;
      nxt_reg_up = 1'b0;
      nxt_reg_down = 1'b0;
      nxt_step_ctrl[INC_BIT] = 1'b0;
      nxt_step_ctrl[DEC_BIT] = 1'b0;
      if (REQ.wr) begin
         case (REQ.addr)
            STEP_CTRL_ADDR: begin
               nxt_step_ctrl[MASK_TOP:FRAC_MASK_LSB] = REQ.wdata[MASK_TOP:FRAC_MASK_LSB];
               nxt_step_ctrl[SRC_BIT] = REQ.wdata[SRC_BIT];
               // both set together cancel out, and both still clear
               if (REQ.wdata[INC_BIT] != REQ.wdata[DEC_BIT]) begin
                  nxt_reg_up = REQ.wdata[INC_BIT];
                  nxt_reg_down = REQ.wdata[DEC_BIT];
               end
               nxt_step_ctrl[INC_BIT] = REQ.wdata[INC_BIT];
               nxt_step_ctrl[DEC_BIT] = REQ.wdata[DEC_BIT];
            end
            CHAN_PWR_ADDR: begin
               nxt_chan_pwr = REQ.wdata;
            end
            PLL_PWR_ADDR: begin
               nxt_pll_pwr = REQ.wdata;
            end
            default: begin
               nxt_pll_pwr = pll_pwr_ff;
            end
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         step_ctrl_ff <= STEP_CTRL_RST;
         chan_pwr_ff <= CHAN_PWR_RST;
         pll_pwr_ff <= PLL_PWR_RST;
         reg_up_ff <= 1'b0;
         reg_down_ff <= 1'b0;
      end else begin
         step_ctrl_ff <= nxt_step_ctrl;
         chan_pwr_ff <= nxt_chan_pwr;
         pll_pwr_ff <= nxt_pll_pwr;
         reg_up_ff <= nxt_reg_up;
         reg_down_ff <= nxt_reg_down;
      end
   end

   // step source selection; simultaneous pin edges also cancel
   always_comb begin
      step.int_sel = step_ctrl_ff[MASK_TOP:INT_MASK_LSB];
      step.frac_sel = step_ctrl_ff[INT_MASK_LSB-1:FRAC_MASK_LSB];
      if (step_ctrl_ff[SRC_BIT]) begin
         step.up = reg_up_ff;
         step.down = reg_down_ff;
      end else begin
         step.up = pin_up_edge && !pin_down_edge;
         step.down = pin_down_edge && !pin_up_edge;
      end
      step_valid = step.up || step.down;
   end

   dspr_word_bank u_bank (
      .clk(CLK),
      .rst(RST),
      .step(step),
      .step_valid(step_valid),
      .int_size(INT_STEP_SIZE),
      .frac_size(FRAC_STEP_SIZE),
      .boundary(DIV_BOUNDARY),
      .int_init(INT_WORD_INIT),
      .frac_init(FRAC_WORD_INIT),
      .int_word(INT_WORD),
      .frac_word(FRAC_WORD)
   );

   // read path, one cycle after the strobe; unmapped reads return zero
   always_comb begin
      nxt_rvalid = REQ.rd;
      nxt_rdata = '0;
      if (REQ.rd) begin
         case (REQ.addr)
            STEP_CTRL_ADDR: nxt_rdata = step_ctrl_ff;
            CHAN_PWR_ADDR: nxt_rdata = chan_pwr_ff;
            PLL_PWR_ADDR: nxt_rdata = pll_pwr_ff;
            default: nxt_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         rdata_ff <= '0;
         rvalid_ff <= 1'b0;
      end else begin
         rdata_ff <= nxt_rdata;
         rvalid_ff <= nxt_rvalid;
      end
   end

   assign RDATA = rdata_ff;
   assign RVALID = rvalid_ff;

   genvar c;
   generate
      for (c = 0; c < NUM_CH; c++) begin : g_pwr
         assign REGULATOR_OFF[c] = chan_pwr_ff[c*PWR_STRIDE+REG_OFF_LSB];
         assign FRAC_DIVIDER_OFF[c] = chan_pwr_ff[c*PWR_STRIDE+FRAC_OFF_LSB];
      end
   endgenerate

   assign PLL_POWER_DOWN = pll_pwr_ff;
endmodule : dspr_regs

// file: logic/dspr_pkg.sv
/*
 * constants and carrier types for the divider step and channel power registers.
 * assumes a 16-bit word register port decoded by the serial configuration front end.
 */
package dspr_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int NUM_CH = 4;
   localparam int INT_W = 16;
   localparam int FRAC_W = 24;
   localparam logic [ADDR_W-1:0] STEP_CTRL_ADDR = 8'h03;
   localparam logic [ADDR_W-1:0] CHAN_PWR_ADDR = 8'h04;
   localparam logic [ADDR_W-1:0] PLL_PWR_ADDR = 8'h05;
   localparam logic [DATA_W-1:0] STEP_CTRL_RST = 16'h0000;
   localparam logic [DATA_W-1:0] CHAN_PWR_RST = 16'h0054;
   localparam logic [DATA_W-1:0] PLL_PWR_RST = 16'h0030;
   // step control field positions
   localparam int SRC_BIT = 0;
   localparam int INC_BIT = 1;
   localparam int DEC_BIT = 2;
   localparam int FRAC_MASK_LSB = 3;
   localparam int INT_MASK_LSB = 7;
   localparam int MASK_TOP = 10;
   // channel power field positions, channel n at 2n (frac) and 2n+1 (regulator)
   localparam int FRAC_OFF_LSB = 0;
   localparam int REG_OFF_LSB = 1;
   localparam int PWR_STRIDE = 2;
   localparam int PIN_SYNC = 3;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } dspr_req_type;

   typedef struct packed {
      logic [NUM_CH-1:0] int_sel;
      logic [NUM_CH-1:0] frac_sel;
      logic up;
      logic down;
   } dspr_step_type;
endpackage : dspr_pkg

// file: logic/dspr_word_bank.sv
/*
 * holds the divider words of all four channels and applies steps to them.
 * assumes the step strobe and the per-channel boundary inputs share the core clock.
 */
`timescale 1ns/100ps
module dspr_word_bank
   import dspr_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // step request
   input wire dspr_step_type step,
   input wire logic step_valid,
   input wire logic [INT_W-1:0] int_size,
   input wire logic [FRAC_W-1:0] frac_size,
   input wire logic [NUM_CH-1:0] boundary,
   // preset words and result
   input wire logic [NUM_CH*INT_W-1:0] int_init,
   input wire logic [NUM_CH*FRAC_W-1:0] frac_init,
   output logic [NUM_CH*INT_W-1:0] int_word,
   output logic [NUM_CH*FRAC_W-1:0] frac_word
);
   logic [INT_W-1:0] int_ff [NUM_CH];
   logic [FRAC_W-1:0] frac_ff [NUM_CH];
   logic [INT_W-1:0] int_pend_ff [NUM_CH];
   logic [FRAC_W-1:0] frac_pend_ff [NUM_CH];
   logic [NUM_CH-1:0] pend_ff;
   logic loaded_ff;

   always_ff @(posedge clk) begin
      if (rst) begin
         loaded_ff <= 1'b0;
      end else begin
         loaded_ff <= 1'b1;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         logic [INT_W-1:0] nxt_int_pend;
         logic [FRAC_W-1:0] nxt_frac_pend;
         logic nxt_pend;
         logic [INT_W-1:0] nxt_int;
         logic [FRAC_W-1:0] nxt_frac;
         always_comb begin
            nxt_int_pend = pend_ff[g] ? int_pend_ff[g] : int_ff[g];
            nxt_frac_pend = pend_ff[g] ? frac_pend_ff[g] : frac_ff[g];
            nxt_pend = pend_ff[g];
            if (step_valid && step.int_sel[g]) begin
               nxt_int_pend = step.up ? nxt_int_pend + int_size : nxt_int_pend - int_size;
               nxt_pend = 1'b1;
            end
            if (step_valid && step.frac_sel[g]) begin
               nxt_frac_pend = step.up ? nxt_frac_pend + frac_size : nxt_frac_pend - frac_size;
               nxt_pend = 1'b1;
            end
            nxt_int = int_ff[g];
            nxt_frac = frac_ff[g];
            if (!loaded_ff) begin
               nxt_int = int_init[g*INT_W +: INT_W];
               nxt_frac = frac_init[g*FRAC_W +: FRAC_W];
               nxt_pend = 1'b0;
            end else if (boundary[g] && pend_ff[g]) begin
               nxt_int = int_pend_ff[g];
               nxt_frac = frac_pend_ff[g];
               nxt_pend = step_valid && (step.int_sel[g] || step.frac_sel[g]);
            end
         end
         always_ff @(posedge clk) begin
            if (rst) begin
               int_ff[g] <= '0;
               frac_ff[g] <= '0;
               int_pend_ff[g] <= '0;
               frac_pend_ff[g] <= '0;
               pend_ff[g] <= 1'b0;
            end else begin
               int_ff[g] <= nxt_int;
               frac_ff[g] <= nxt_frac;
               int_pend_ff[g] <= nxt_int_pend;
               frac_pend_ff[g] <= nxt_frac_pend;
               pend_ff[g] <= nxt_pend;
            end
         end
         assign int_word[g*INT_W +: INT_W] = int_ff[g];
         assign frac_word[g*FRAC_W +: FRAC_W] = frac_ff[g];
      end
   endgenerate
endmodule : dspr_word_bank

// file: verif/dspr_regs_assertions.sv
/* port checker for dspr_regs: read answers, power outputs, step bits, word loads.
   assumes a bind to dspr_regs and a reset of two cycles or more. */
`timescale 1ns/100ps
module dspr_regs_assertions
   import dspr_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // register port
   input wire dspr_req_type REQ,
   input wire logic [DATA_W-1:0] RDATA,
   input wire logic RVALID,
   // words and power
   input wire logic [NUM_CH-1:0] DIV_BOUNDARY,
   input wire logic [NUM_CH*INT_W-1:0] INT_WORD,
   input wire logic [NUM_CH*FRAC_W-1:0] FRAC_WORD,
   input wire logic [NUM_CH-1:0] REGULATOR_OFF,
   input wire logic [NUM_CH-1:0] FRAC_DIVIDER_OFF,
   input wire logic [DATA_W-1:0] PLL_POWER_DOWN
);
   default clocking dspr_cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   wire logic wr_pwr = REQ.wr && REQ.addr == CHAN_PWR_ADDR;
   wire logic wr_pll = REQ.wr && REQ.addr == PLL_PWR_ADDR;
   wire logic wr_step = REQ.wr && REQ.addr == STEP_CTRL_ADDR;
   // last channel power word, so the output check spans latency 1 or 2
   logic [DATA_W-1:0] last_pwr_ff;
   always_ff @(posedge CLK) if (wr_pwr) last_pwr_ff <= REQ.wdata;
   a_read_gets_answer: assert property (REQ.rd |=> RVALID) else $error("read not answered");
   a_no_stray_valid: assert property (RVALID |-> $past(REQ.rd)) else $error("answer without read");
   a_reset_power_outs: assert property ($fell(RST) |-> FRAC_DIVIDER_OFF == 4'he && REGULATOR_OFF == 4'h0
      && PLL_POWER_DOWN == 16'h0030) else $error("power outputs not at reset values");
   a_regulator_map: assert property (wr_pwr ##1 !wr_pwr |=> REGULATOR_OFF ==
      {last_pwr_ff[7], last_pwr_ff[5], last_pwr_ff[3], last_pwr_ff[1]}) else $error("regulator bits wrong");
   a_frac_off_map: assert property (wr_pwr ##1 !wr_pwr |=> FRAC_DIVIDER_OFF ==
      {last_pwr_ff[6], last_pwr_ff[4], last_pwr_ff[2], last_pwr_ff[0]}) else $error("divider off bits wrong");
   a_pll_copy: assert property (wr_pll ##1 !wr_pll |=> PLL_POWER_DOWN == $past(REQ.wdata, 2))
      else $error("pll power output wrong");
   a_step_self_clear: assert property (wr_step ##1 !REQ.wr ##1 (REQ.rd && REQ.addr == STEP_CTRL_ADDR)
      |=> RDATA == ($past(REQ.wdata, 3) & 16'h07f9)) else $error("step control readback wrong");
   a_int_word_boundary: assert property ($changed(INT_WORD[INT_W-1:0]) |-> $past(DIV_BOUNDARY[0])
      || $past(RST, 2)) else $error("integer word moved off boundary");
   a_frac_word_boundary: assert property ($changed(FRAC_WORD[NUM_CH*FRAC_W-1 -: FRAC_W])
      |-> $past(DIV_BOUNDARY[3]) || $past(RST, 2)) else $error("fractional word moved off boundary");
   c_pwr_write: cover property (wr_pwr ##1 !wr_pwr);
   c_step_read: cover property (wr_step ##2 REQ.rd);
   c_int_step: cover property ($changed(INT_WORD) && !$past(RST, 2));
endmodule : dspr_regs_assertions
bind dspr_regs dspr_regs_assertions dspr_regs_assertions_inst (.CLK(CLK), .RST(RST), .REQ(REQ), .RDATA(RDATA),
   .RVALID(RVALID), .DIV_BOUNDARY(DIV_BOUNDARY), .INT_WORD(INT_WORD), .FRAC_WORD(FRAC_WORD),
   .REGULATOR_OFF(REGULATOR_OFF), .FRAC_DIVIDER_OFF(FRAC_DIVIDER_OFF), .PLL_POWER_DOWN(PLL_POWER_DOWN));

// file: verif/test_dspr_regs.sv
/* self-checking bench for dspr_regs: reset values, power registers, steps from register and pins.
   assumes the checker is bound on its own; reads queue their expected data. */
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module test_dspr_regs
   import dspr_pkg::*;
;
   logic CLK = 0;
   logic RST = 1;
   logic up_pin = 0;
   logic dn_pin = 0;
   logic rvalid;
   dspr_req_type req = '0;
   logic [DATA_W-1:0] rdata, pll, d, ctl, q_exp;
   logic [INT_W-1:0] isz;
   logic [FRAC_W-1:0] fsz;
   logic [NUM_CH-1:0] bnd = '0, reg_off, frac_off;
   logic [NUM_CH*INT_W-1:0] iinit, iword;
   logic [NUM_CH*FRAC_W-1:0] finit, fword;
   logic [INT_W-1:0] ei [NUM_CH];
   logic [FRAC_W-1:0] ef [NUM_CH];
   logic [DATA_W-1:0] expq [$];
   int errors = 0, total_checks = 0, seed = 32'h0f13_68dd;
   always #2 CLK = ~CLK;
   dspr_regs dspr_regs_inst (.CLK(CLK), .RST(RST), .REQ(req), .RDATA(rdata), .RVALID(rvalid), .STEP_UP_PIN(up_pin),
      .STEP_DOWN_PIN(dn_pin), .INT_STEP_SIZE(isz), .FRAC_STEP_SIZE(fsz), .DIV_BOUNDARY(bnd), .INT_WORD_INIT(iinit),
      .FRAC_WORD_INIT(finit), .INT_WORD(iword), .FRAC_WORD(fword), .REGULATOR_OFF(reg_off),
      .FRAC_DIVIDER_OFF(frac_off), .PLL_POWER_DOWN(pll));
   // one gap cycle between requests keeps each strobe a single pulse
   task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      @(negedge CLK);
      req = '{wr: w, rd: !w, addr: a, wdata: v};
      if (!w) expq.push_back(v);
      @(negedge CLK);
      req = '0;
   endtask : bus
   task automatic chk_words;
      for (int n = 0; n < NUM_CH; n++) begin
         `CHK("int_word", ei[n], iword[n*INT_W +: INT_W])
         `CHK("frac_word", ef[n], fword[n*FRAC_W +: FRAC_W])
      end
   endtask : chk_words
   // the source not selected steps the other way, so a wrong source shows up
   task automatic step;
      logic [DATA_W-1:0] sw;
      sw = {ctl[DATA_W-1:DEC_BIT+1], ctl[INC_BIT], ctl[DEC_BIT], ctl[SRC_BIT]};
      bnd = '0;
      bus(1, STEP_CTRL_ADDR, ctl[SRC_BIT] ? ctl : sw);
      bus(0, STEP_CTRL_ADDR, ctl & 16'h07f9);
      up_pin = ctl[SRC_BIT] ? sw[INC_BIT] : ctl[INC_BIT];
      dn_pin = ctl[SRC_BIT] ? sw[DEC_BIT] : ctl[DEC_BIT];
      repeat (3) @(negedge CLK);
      up_pin = 0;
      dn_pin = 0;
      repeat (8) @(negedge CLK);
      chk_words;
      if (ctl[INC_BIT] ^ ctl[DEC_BIT]) for (int n = 0; n < NUM_CH; n++) begin
         if (ctl[INT_MASK_LSB+n]) ei[n] = ctl[INC_BIT] ? ei[n] + isz : ei[n] - isz;
         if (ctl[FRAC_MASK_LSB+n]) ef[n] = ctl[INC_BIT] ? ef[n] + fsz : ef[n] - fsz;
      end
      bnd = 4'hf;
      repeat (3) @(negedge CLK);
      chk_words;
      bus(0, STEP_CTRL_ADDR, ctl & 16'h07f9);
   endtask : step
   always @(negedge CLK) if (rvalid === 1'b1) begin
      q_exp = expq.pop_front();
      `CHK("rdata", q_exp, rdata)
   end
   initial begin
      isz = 16'($random(seed));
      fsz = 24'($random(seed));
      iinit = {$random(seed), $random(seed)};
      finit = {$random(seed), $random(seed), $random(seed)};
      for (int n = 0; n < NUM_CH; n++) begin
         ei[n] = iinit[n*INT_W +: INT_W];
         ef[n] = finit[n*FRAC_W +: FRAC_W];
      end
      repeat (3) @(negedge CLK);
      RST = 0;
      bus(0, STEP_CTRL_ADDR, 16'h0000);
      bus(0, CHAN_PWR_ADDR, 16'h0054);
      bus(0, PLL_PWR_ADDR, 16'h0030);
      bus(0, 8'h06, 16'h0000);
      `CHK("frac_off", 4'he, frac_off)
      `CHK("reg_off", 4'h0, reg_off)
      chk_words;
      for (int i = 0; i < 12; i++) begin
         d = 16'($random(seed));
         bus(1, CHAN_PWR_ADDR, d);
         bus(0, CHAN_PWR_ADDR, d);
         `CHK("reg_off", {d[7], d[5], d[3], d[1]}, reg_off)
         `CHK("frac_off", {d[6], d[4], d[2], d[0]}, frac_off)
         bus(1, PLL_PWR_ADDR, ~d);
         bus(0, PLL_PWR_ADDR, ~d);
         `CHK("pll", ~d, pll)
         ctl = {5'h00, d[15:8], 2'(i % 3 + 1), i >= 6};
         step;
      end
      // let the last answer be popped before the queue is counted
      repeat (2) @(negedge CLK);
      `CHK("open_reads", 0, expq.size())
      print_verdict;
   end
   initial begin
      #40000;
      errors++;
      print_verdict;
   end
   task automatic print_verdict;
      if (errors == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : print_verdict
endmodule : test_dspr_regs
